// >>> bench/ccg_top_assertions.sv
// Checker for the clock generation top: register effects, refusals, hibernate and tick gating.
// Assumes it is bound to ccg_top and sees only that module's ports.
`timescale 1ns/100ps
module ccg_top_assertions
    import ccg_pkg::*;
(
    input wire logic        sys_clk_in,
    input wire logic        srst_in,
    input wire logic [3:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic [6:0]  pll_mult_out,
    input wire logic        pll_relock_out,
    input wire logic [3:0]  core_volt_out,
    input wire logic        core_power_out,
    input wire logic        reg_bypass_out,
    input wire logic        boot_start_out,
    input wire logic        core_tick_out,
    input wire logic        sys_tick_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    sequence s_mult_wr;
        wr_in && addr_in == CCG_ADDR_PLL && wdata_in[6:0] != 7'h00;
    endsequence
    sequence s_reg_wr;
        wr_in && addr_in == CCG_ADDR_REG;
    endsequence
    // Reads answer only in the cycle after the strobe, so a stray value on the bus is caught here.
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000) else $error("rdata not idle"); 
    a_mult_write: assert property (s_mult_wr |=> ##1 pll_mult_out == $past(wdata_in[6:0], 2)) else $error("mult");
    a_mult_nonzero: assert property (pll_mult_out != 7'h00) else $error("mult zero");
    // Register effects reach the ports through two flops, so they are looked at two edges on.
    a_relock_start: assert property (s_mult_wr |=> ##1 pll_relock_out) else $error("no relock");
    a_div_no_relock: assert property (wr_in && addr_in == CCG_ADDR_DIV && !pll_relock_out |=> ##1
        !pll_relock_out) else $error("divider relock");
    a_volt_write: assert property (s_reg_wr |=> ##1 core_volt_out == $past(wdata_in[7:4], 2))
        else $error("volt");
    a_bypass_write: assert property (s_reg_wr |=> ##1 reg_bypass_out == $past(wdata_in[8], 2))
        else $error("byp");
    a_hib_power: assert property (s_reg_wr ##0 (wdata_in[1:0] == REG_REGULATOR_FREQUENCY_FIELD_OFF && !wdata_in[8])
        |=> ##1 !core_power_out) else $error("power on");
    a_hib_ticks: assert property (!core_power_out [*4] |-> !sys_tick_out && !core_tick_out)
        else $error("tick in hibernate");
    a_lock_ticks: assert property (pll_relock_out [*4] |-> !sys_tick_out && !core_tick_out)
        else $error("tick in relock");
    a_boot_pulse: assert property (boot_start_out |=> !boot_start_out) else $error("boot pulse");
endmodule
bind ccg_top ccg_top_assertions u_chk (.*);

// >>> bench/test_core_system_clock_generation.sv
// Self-checking bench for the clock generation top over its plain register port.
// Assumes a 10 MHz bus clock and a VCO tick with one rising edge every two bus cycles.
`timescale 1ns/100ps
module test_core_system_clock_generation
    import ccg_pkg::*;
;
    logic        clk = 1'b0, srst = 1'b1, rst_pin_n = 1'b1, vco = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, q_exp[$];
    logic [6:0]  mult, m;
    logic [3:0]  volt, v;
    logic        relock, power, byp, boot, ctick, stick, pin, pin_d = 1'b0;
    int          n_errors = 0, n_checks = 0, seed = 32'hf055;
    ccg_top dut (.sys_clk_in(clk), .srst_in(srst), .reset_pin_n_in(rst_pin_n), .vco_tick_in(vco),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .pll_mult_out(mult),
        .pll_relock_out(relock), .core_volt_out(volt), .core_power_out(power), .reg_bypass_out(byp),
        .boot_start_out(boot), .core_tick_out(ctick), .sys_tick_out(stick), .sys_clock_pin_out(pin));
    always #50 clk = ~clk;
    always @(posedge clk) vco <= ~vco;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // The monitor takes the oldest note whenever read data stands on the bus.
    always @(posedge clk)
    begin
        rd_d <= rd;
        pin_d <= pin;
        if (rd_d)
            check(rdata, q_exp.pop_front());
    end
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        q_exp.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    function automatic logic sig(input int sel);
        return sel == 0 ? stick : sel == 1 ? ctick : (pin && !pin_d);
    endfunction
    // Cycles between two events; the wait is bounded so a dead clock shows as a wrong count.
    task automatic period(input int sel, input logic [15:0] e);
        int n;
        n = 0;
        do @(posedge clk); while (sig(sel) !== 1'b1 && ++n < 200);
        n = 0;
        do @(posedge clk); while (sig(sel) !== 1'b1 && ++n < 200);
        check(16'(n + 1), e);
    endtask
    initial
    begin
        #(20000 * 100);
        n_errors++;
        end_sim();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (70) @(posedge clk);
        check({9'h0, mult}, 16'h0010);
        check({12'h0, volt}, 16'h0008);
        check({13'h0, pin, byp, power}, 16'h0001);
        bus_rd(CCG_ADDR_DIV, 16'h0004);
        bus_rd(CCG_ADDR_PLL, 16'h0010);
        bus_rd(CCG_ADDR_REG, 16'h0083);
        bus_rd(CCG_ADDR_OUTCTL, 16'h0000);
        bus_rd(4'h9, 16'h0000);
        period(0, 16'd8);
        period(1, 16'd2);
        bus_wr(CCG_ADDR_DIV, 16'h0013);
        bus_rd(CCG_ADDR_DIV, 16'h0013);
        check({15'h0, relock}, 16'h0000);
        repeat (20) @(posedge clk);
        period(0, 16'd6);
        for (int c = 0; c < 4; c++)
        begin
            bus_wr(CCG_ADDR_DIV, 16'(c * 16 + 2));
            repeat (40) @(posedge clk);
            period(1, 16'(2 << c));
        end
        period(0, 16'd4);
        bus_wr(CCG_ADDR_DIV, 16'h0001);
        bus_rd(CCG_ADDR_DIV, 16'h0002);
        bus_wr(CCG_ADDR_OUTCTL, 16'h0001);
        repeat (10) @(posedge clk);
        period(2, 16'd4);
        for (int i = 0; i < 3; i++)
        begin
            v = 4'($random(seed));
            m = 7'($random(seed)) | 7'h01;
            bus_wr(CCG_ADDR_REG, {7'h00, v[0], v, 4'h3});
            repeat (2) @(posedge clk);
            check({11'h0, byp, volt}, {11'h0, v[0], v});
            bus_rd(CCG_ADDR_REG, {7'h00, v[0], v, 4'h3});
            bus_wr(CCG_ADDR_PLL, {9'h0, m});
            repeat (2) @(posedge clk);
            check({8'h0, relock, mult}, {8'h0, 1'b1, m});
            bus_wr(CCG_ADDR_PLL, 16'h0000);
            check({9'h0, mult}, {9'h0, m});
        end
        repeat (80) @(posedge clk);
        check({15'h0, relock}, 16'h0000);
        bus_wr(CCG_ADDR_REG, 16'h0080);
        repeat (2) @(posedge clk);
        check({15'h0, power}, 16'h0000);
        repeat (10) @(posedge clk);
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clk);
            check({15'h0, stick | ctick}, 16'h0000);
        end
        rst_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_pin_n <= 1'b1;
        for (int i = 0; i < 20 && boot !== 1'b1; i++)
            @(posedge clk);
        check({15'h0, boot}, 16'h0001);
        repeat (2) @(posedge clk);
        check({15'h0, power}, 16'h0001);
        end_sim();
    end
endmodule

// >>> design/ccg_divider.sv
// Glitch-free programmable divider producing a level clock and a one-cycle tick.
// Assumes run_in is a one-cycle source tick; between ticks the count and level hold.
// A new ratio is taken only at the end of a period.
`timescale 1ns/100ps
module ccg_divider
    import ccg_pkg::*;
#(
    parameter int W = 4
)
(
    input  wire logic         sys_clk_in,
    input  wire logic         srst_in,
    input  wire logic         run_in,
    input  wire logic [W-1:0] ratio_in,
    output logic              level_out,
    output logic              tick_out
);

    if (W < 1 || W > 8)
    begin : g_bad_width
        $error("ccg_divider: width out of range");
    end

    logic [W-1:0] count;
    logic [W-1:0] active_ratio;

    // The ratio is latched only when the count wraps, so a period is never cut short.
    // Holding between source ticks keeps a stopped clock resuming mid-period instead of restarting it.
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            count        <= '0;
            active_ratio <= ratio_in;
            tick_out     <= 1'b0;
            level_out    <= 1'b0;
        end
        else if (!run_in)
            tick_out <= 1'b0;
        else if (count >= active_ratio - W'(1))
        begin
            count        <= '0;
            active_ratio <= ratio_in;
            tick_out     <= 1'b1;
            level_out    <= 1'b1;
        end
        else
        begin
            count     <= count + W'(1);
            tick_out  <= 1'b0;
            level_out <= (count + W'(1)) < (active_ratio >> 1);
        end
    end

endmodule

// >>> design/ccg_pkg.sv
// Package for the core and system clock generation block: register map, field layout, reset values.
// Assumes a single 10 MHz register clock and a plain strobe register port.
package ccg_pkg;

    localparam logic [3:0] CCG_ADDR_DIV       = 4'h0;
    localparam logic [3:0] CCG_ADDR_PLL       = 4'h1;
    localparam logic [3:0] CCG_ADDR_REG       = 4'h2;
    localparam logic [3:0] CCG_ADDR_OUTCTL    = 4'h3;
    localparam logic [3:0] CCG_ADDR_STATUS    = 4'h4;

    localparam int SYS_DIV_LSB  = 0;
    localparam int CORE_DIV_LSB = 4;
    localparam int REG_REGULATOR_FREQUENCY_FIELD_LSB = 0;
    localparam int REG_VOLT_LSB = 4;
    localparam int REG_BYP_BIT  = 8;

    localparam logic [3:0] SYS_DIV_RESET   = 4'h4;
    localparam logic [1:0] CORE_DIV_RESET  = 2'h0;
    localparam logic [6:0] PLL_MULT_RESET  = 7'h10;
    localparam logic [1:0] REG_REGULATOR_FREQUENCY_FIELD_RESET  = 2'h3;
    localparam logic [1:0] REG_REGULATOR_FREQUENCY_FIELD_OFF    = 2'h0;
    localparam logic [3:0] REG_VOLT_RESET  = 4'h8;
    localparam logic [3:0] SYS_DIV_MIN     = 4'h2;
    localparam int         VOLT_STEP_MV    = 50;
    localparam logic [7:0] PLL_LOCK_CYCLES = 8'h40;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ccg_bus_t;

    typedef struct packed {
        logic       core_tick;
        logic       sys_tick;
        logic       sys_level;
        logic       core_level;
    } ccg_clocks_t;

endpackage

// >>> design/ccg_top.sv
// Core and system clock generation with regulator control, reached over a plain register port.
// Assumes the input clock pin is already a usable VCO-rate tick source via vco_tick_in from the PLL model.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
// What this block does
// - Software sets core supply level in 50 mV steps via regulator control register.
// - Regulator can be programmed to cut core power, I/O stays powered.
// - Reset pin wakes regulator from power-down and starts boot.
// - Regulator may be disabled and bypassed; core supply then comes externally.
// - Core and system clocks are derived from the input clock through the PLL.
// - PLL multiplier is programmable from one half to sixty-four; the code stops at 127 half steps, 63.5.
// - Multiplier resets to eight; software may change it.
// - Writing the divider register changes clocks on the fly.
// - Clock output mirrors system clock when enabled, off after reset.
// - Peripherals are clocked by the system clock only.
// - Four-bit system divider field value is the VCO to system divisor.
// - System divisors two through fifteen valid; others unsupported.
// - System divider resets to four.
// - System divider change needs no PLL relock.
// - Core divider field selects one, two, four or eight.
// - Core divider resets to one.
// - Writing 00 to regulator frequency field with the bypass bit clear stops clocks and removes core supply.
module ccg_top
    import ccg_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        srst_in,
    input  wire logic        reset_pin_n_in,
    input  wire logic        vco_tick_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    output logic      [6:0]  pll_mult_out,
    output logic             pll_relock_out,
    output logic      [3:0]  core_volt_out,
    output logic             core_power_out,
    output logic             reg_bypass_out,
    output logic             boot_start_out,
    output logic             core_tick_out,
    output logic             sys_tick_out,
    output logic             sys_clock_pin_out
);

    logic [3:0] system_divider_field;
    logic [1:0] core_divider_field;
    logic [6:0] pll_mult;
    logic [1:0] regulator_frequency_field;
    logic [3:0] reg_volt;
    logic       reg_bypass;
    logic       system_clock_output_pin_en;
    logic       hibernate;
    logic [7:0] lock_count;
    logic       rst_meta;
    logic       rst_sync;
    logic       vco_meta;
    logic       vco_sync;
    logic       vco_prev;
    logic       vco_edge;
    logic       clocks_run;
    logic [3:0] sys_ratio;
    logic [3:0] core_ratio;
    logic       sys_level;
    logic       sys_tick;
    logic       core_tick;

    // Pin and the PLL output come from outside this clock's domain.
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            rst_meta <= 1'b1;
            rst_sync <= 1'b1;
            vco_meta <= 1'b0;
            vco_sync <= 1'b0;
            vco_prev <= 1'b0;
        end
        else
        begin
            rst_meta <= reset_pin_n_in;
            rst_sync <= rst_meta;
            vco_meta <= vco_tick_in;
            vco_sync <= vco_meta;
            vco_prev <= vco_sync;
        end
    end

    assign vco_edge = vco_sync && !vco_prev;

    // Divider register: writes land immediately and the dividers pick them up at their next period end.
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            system_divider_field <= SYS_DIV_RESET;
            core_divider_field   <= CORE_DIV_RESET;
        end
        else if (wr_in && addr_in == CCG_ADDR_DIV)
        begin
            // Unsupported divisors are refused so the system clock never runs at VCO rate.
            if (wdata_in[SYS_DIV_LSB +: 4] >= SYS_DIV_MIN)
                system_divider_field <= wdata_in[SYS_DIV_LSB +: 4];
            core_divider_field <= wdata_in[CORE_DIV_LSB +: 2];
        end
    end

    // Multiplier is held in half steps: 1 means one half, 128 would exceed the field, so 127 caps near 64.
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            pll_mult <= PLL_MULT_RESET;
        else if (wr_in && addr_in == CCG_ADDR_PLL && wdata_in[6:0] != 7'h00)
            pll_mult <= wdata_in[6:0];
    end

    // A multiplier change forces a relock wait; a divider change does not.
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            lock_count <= PLL_LOCK_CYCLES;
        else if (wr_in && addr_in == CCG_ADDR_PLL && wdata_in[6:0] != 7'h00)
            lock_count <= PLL_LOCK_CYCLES;
        else if (lock_count != 8'h00)
            lock_count <= lock_count - 8'h01;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            regulator_frequency_field <= REG_REGULATOR_FREQUENCY_FIELD_RESET;
            reg_volt                  <= REG_VOLT_RESET;
            reg_bypass                <= 1'b0;
        end
        else if (wr_in && addr_in == CCG_ADDR_REG)
        begin
            regulator_frequency_field <= wdata_in[REG_REGULATOR_FREQUENCY_FIELD_LSB +: 2];
            reg_volt                  <= wdata_in[REG_VOLT_LSB +: 4];
            reg_bypass                <= wdata_in[REG_BYP_BIT];
        end
    end

    // Hibernate survives only until the reset pin pulls it back; then boot starts once.
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            hibernate      <= 1'b0;
            boot_start_out <= 1'b0;
        end
        else if (hibernate && !rst_sync)
        begin
            hibernate      <= 1'b0;
            boot_start_out <= 1'b1;
        end
        else
        begin
            boot_start_out <= 1'b0;
            // The bypass bit of the same write decides, so one write may both clear bypass and power down.
            if (wr_in && addr_in == CCG_ADDR_REG && wdata_in[REG_REGULATOR_FREQUENCY_FIELD_LSB +: 2] == REG_REGULATOR_FREQUENCY_FIELD_OFF
                && !wdata_in[REG_BYP_BIT])
                hibernate <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            system_clock_output_pin_en <= 1'b0;
        else if (wr_in && addr_in == CCG_ADDR_OUTCTL)
            system_clock_output_pin_en <= wdata_in[0];
    end

    assign clocks_run = !hibernate && lock_count == 8'h00;
    assign sys_ratio  = system_divider_field;
    assign core_ratio = 4'h1 << core_divider_field;

    // Both dividers count VCO edges, so the prescalers turn VCO edges into ticks.
    ccg_divider #(.W(4)) u_sys_div (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .run_in     (clocks_run && vco_edge),
        .ratio_in   (sys_ratio),
        .level_out  (sys_level),
        .tick_out   (sys_tick)
    );

    ccg_divider #(.W(4)) u_core_div (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .run_in     (clocks_run && vco_edge),
        .ratio_in   (core_ratio),
        .level_out  (),
        .tick_out   (core_tick)
    );

    // The dividers hold between VCO edges; their ticks are gated again so none leaks out once clocks stop.
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            core_tick_out <= 1'b0;
            sys_tick_out  <= 1'b0;
        end
        else
        begin
            core_tick_out <= core_tick && clocks_run;
            sys_tick_out  <= sys_tick && clocks_run;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            sys_clock_pin_out <= 1'b0;
        else
            sys_clock_pin_out <= system_clock_output_pin_en && clocks_run && sys_level;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            pll_mult_out   <= PLL_MULT_RESET;
            pll_relock_out <= 1'b1;
            core_volt_out  <= REG_VOLT_RESET;
            core_power_out <= 1'b1;
            reg_bypass_out <= 1'b0;
        end
        else
        begin
            pll_mult_out   <= pll_mult;
            pll_relock_out <= lock_count != 8'h00;
            core_volt_out  <= reg_volt;
            core_power_out <= !hibernate;
            reg_bypass_out <= reg_bypass;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            rdata_out <= 16'h0000;
        else if (rd_in)
        begin
            unique case (addr_in)
                CCG_ADDR_DIV:    rdata_out <= {10'h000, core_divider_field, system_divider_field};
                CCG_ADDR_PLL:    rdata_out <= {9'h000, pll_mult};
                CCG_ADDR_REG:    rdata_out <= {7'h00, reg_bypass, reg_volt, 2'h0, regulator_frequency_field};
                CCG_ADDR_OUTCTL: rdata_out <= {15'h0000, system_clock_output_pin_en};
                CCG_ADDR_STATUS: rdata_out <= {13'h0000, lock_count != 8'h00, hibernate, clocks_run};
                default:         rdata_out <= 16'h0000;
            endcase
        end
        else
            rdata_out <= 16'h0000;
    end

endmodule
